// file: aec_top.sv
// event, reset and input control of a bridge sigma-delta converter, with an axi4-lite slave
// assumes inputs synchronous to aclk; the filter, modulator and calibration engine sit outside
`timescale 1ns/1ns
module aec_top import aec_pkg::*; #(
  parameter int DATA_W = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_pin_n,
  input wire logic standby_n,
  input wire logic sync_n,
  input wire logic ser_strobe,
  input wire logic ser_bit,
  input wire logic word_valid,
  input wire logic [DATA_W-1:0] word,
  input wire logic word_settled,
  input wire logic ref_missing,
  input wire logic cal_done,
  output aec_mode_type mode_cfg,
  output aec_dac_type dac_cfg,
  output logic filter_reset,
  output logic analog_power_down,
  output logic serial_reset,
  output logic data_ready_n,
  output logic irq
);
  aec_mode_type mode_r, mode_nxt;
  aec_dac_type dac_r;
  logic [DATA_W-1:0] data_r;
  logic [IRQ_W-1:0] ista_r, ista_nxt, imsk_r, iset;
  logic [5:0] ones_r;
  logic rdy_r, filter_settled_flag_r, fr_r, pd_r, por_pd_r, sr_r, irq_r;
  logic aw_h_r, w_h_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [AXI_AW-1:0] awaddr_r;
  logic [AXI_DW-1:0] wdata_r, rdata_r, wmerged, rd_mux;
  logic [3:0] wstrb_r;
  logic wr_fire, ar_fire, mode_wr, md_wr_ev, data_rd, ones_hit, rst_ev;
  logic filt_ev, chan_chg, any_ev, conv_mode, word_take, cal_end, rd_ok, wr_ok;
  logic [2:0] op_nxt;

  // byte-lane merge of a write into the old register value
  function automatic logic [AXI_DW-1:0] merge(input logic [AXI_DW-1:0] old,
                                              input logic [AXI_DW-1:0] nw, input logic [3:0] strb);
    logic [AXI_DW-1:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // unipolar: negatives clamp to zero; doubled, low bit filled in the upper half only, so midscale is 100..0
  function automatic logic [DATA_W-1:0] code(input logic [DATA_W-1:0] w, input logic bip);
    logic [DATA_W-1:0] c;
    c = '0;
    if (bip) begin
      c = {~w[DATA_W-1], w[DATA_W-2:0]};
    end else if (!w[DATA_W-1]) begin
      c = {w[DATA_W-2:0], w[DATA_W-2] & w[0]};
    end
    return c;
  endfunction : code

  // bus-side events
  assign wr_fire = aw_h_r & w_h_r & !bvalid_r;
  assign ar_fire = s_axi_arvalid & arready_r;
  assign mode_wr = wr_fire & (awaddr_r == OFF_MODE);
  assign md_wr_ev = mode_wr & wstrb_r[0];
  assign data_rd = ar_fire & (s_axi_araddr == OFF_DATA);
  assign wmerged = merge({{(AXI_DW-MODE_W){1'b0}}, mode_r}, wdata_r, wstrb_r);
  assign wr_ok = (awaddr_r == OFF_MODE) | (awaddr_r == OFF_DAC) | (awaddr_r == OFF_ISTA)
               | (awaddr_r == OFF_IMSK);
  assign rd_ok = (s_axi_araddr <= OFF_IMSK) & (s_axi_araddr[1:0] == 2'h0); // every aligned word up to the mask

  // hardware and serial events, and their grouping
  assign ones_hit = ser_strobe & ser_bit & (ones_r == 6'(SER_ONES - 1));
  assign rst_ev = !reset_pin_n | ones_hit;
  assign filt_ev = rst_ev | !standby_n | !sync_n | md_wr_ev;
  assign chan_chg = mode_wr & !rst_ev & ({mode_nxt.channel_select_bit1, mode_nxt.channel_select_bit0}
                    != {mode_r.channel_select_bit1, mode_r.channel_select_bit0});
  assign any_ev = filt_ev | chan_chg | data_rd;
  assign conv_mode = (mode_r.operating_mode_bits == MD_CONT) | (mode_r.operating_mode_bits == MD_SINGLE);
  assign word_take = word_valid & conv_mode & !filt_ev & !fr_r;
  assign cal_end = cal_done & mode_r.operating_mode_bits[MD_CAL_BIT] & !any_ev;
  assign op_nxt = mode_nxt.operating_mode_bits;

  // mode register: reset wins over a write, a write over calibration end
  always_comb begin
    mode_nxt = mode_r;
    if (rst_ev) begin
      mode_nxt = aec_mode_type'(MODE_RST);
    end else if (mode_wr) begin
      mode_nxt = aec_mode_type'(wmerged[MODE_W-1:0]);
    end else if (cal_end) begin
      mode_nxt.operating_mode_bits = MD_IDLE;
    end
  end

  // standby leaves mode untouched; only the bus, a reset or calibration end changes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= aec_mode_type'(MODE_RST);
    end else if (ce) begin
      mode_r <= mode_nxt;
    end
  end

  // offset dac code, held across standby and sync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_r <= aec_dac_type'(DAC_RST);
    end else if (ce) begin
      if (rst_ev) begin
        dac_r <= aec_dac_type'(DAC_RST);
      end else if (wr_fire & (awaddr_r == OFF_DAC) & wstrb_r[0]) begin
        dac_r <= aec_dac_type'(wdata_r[DAC_W-1:0]);
      end
    end
  end

  // consecutive ones counter on the serial input; any zero starts over
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ones_r <= '0;
    end else if (ce) begin
      if (!reset_pin_n | ones_hit) begin
        ones_r <= '0;
      end else if (ser_strobe) begin
        ones_r <= ser_bit ? ones_r + 6'h01 : 6'h00;
      end
    end
  end

  // filter and serial reset pulses; standby and sync hold filter reset while low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fr_r <= 1'b1;
      sr_r <= 1'b1;
    end else if (ce) begin
      fr_r <= filt_ev;
      sr_r <= rst_ev;
    end
  end

  // analog power: off after power-on until a mode write or reset, in standby and in mode 011
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_pd_r <= 1'b1;
      pd_r <= 1'b1;
    end else if (ce) begin
      por_pd_r <= por_pd_r & !rst_ev & !md_wr_ev;
      pd_r <= !standby_n | (op_nxt == MD_PDOWN) | (por_pd_r & !rst_ev & !md_wr_ev);
    end
  end

  // ready flag: any event sets it and wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdy_r <= 1'b1;
    end else if (ce) begin
      if (any_ev) begin
        rdy_r <= 1'b1;
      end else if ((word_take & word_settled) | cal_end) begin
        rdy_r <= 1'b0;
      end
    end
  end

  // settled flag: data reads leave it alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filter_settled_flag_r <= 1'b1;
    end else if (ce) begin
      if (filt_ev) begin
        filter_settled_flag_r <= 1'b1;
      end else if (word_take & word_settled) begin
        filter_settled_flag_r <= 1'b0;
      end
    end
  end

  // result register; a missing reference forces all ones so software need not poll it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_r <= '0;
    end else if (ce) begin
      if (rst_ev) begin
        data_r <= '0;
      end else if (word_take) begin
        data_r <= ref_missing ? '1 : code(word, mode_r.bipolar);
      end
    end
  end

  // sticky interrupt status, write one to clear; a new event beats the clear
  always_comb begin
    iset = '0;
    iset[IB_WORD] = word_take;
    iset[IB_CAL] = cal_end;
    iset[IB_NOREF] = word_take & ref_missing;
    iset[IB_SOFT] = rst_ev;
    ista_nxt = ista_r;
    if (wr_fire & (awaddr_r == OFF_ISTA) & wstrb_r[0]) begin
      ista_nxt = ista_r & ~wdata_r[IRQ_W-1:0];
    end
    ista_nxt = ista_nxt | iset;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ista_r <= IRQ_RST;
      imsk_r <= IRQ_RST;
      irq_r <= 1'b0;
    end else if (ce) begin
      ista_r <= ista_nxt;
      if (wr_fire & (awaddr_r == OFF_IMSK) & wstrb_r[0]) begin
        imsk_r <= wdata_r[IRQ_W-1:0];
        irq_r <= |(ista_nxt & wdata_r[IRQ_W-1:0]);
      end else begin
        irq_r <= |(ista_nxt & imsk_r);
      end
    end
  end

  // write channel: address and data taken in either order, response once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h_r <= 1'b0;
      w_h_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (ce) begin
      if (s_axi_awvalid & awready_r) begin
        aw_h_r <= 1'b1;
        awready_r <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end else if (!aw_h_r) begin
        awready_r <= 1'b1;
      end
      if (s_axi_wvalid & wready_r) begin
        w_h_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (!w_h_r) begin
        wready_r <= 1'b1;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r & s_axi_bready) begin
        bvalid_r <= 1'b0;
        aw_h_r <= 1'b0;
        w_h_r <= 1'b0;
      end
    end
  end

  // read mux; unmapped addresses read zero with an error response
  always_comb begin
    rd_mux = '0;
    unique case (s_axi_araddr)
      OFF_MODE: rd_mux[MODE_W-1:0] = mode_r;
      OFF_DAC: rd_mux[DAC_W-1:0] = dac_r;
      OFF_STAT: begin
        rd_mux[ST_RDY] = rdy_r;
        rd_mux[ST_FILTER_SETTLED_FLAG] = filter_settled_flag_r;
        rd_mux[ST_NOREF] = ref_missing;
      end
      OFF_DATA: rd_mux[DATA_W-1:0] = data_r;
      OFF_ISTA: rd_mux[IRQ_W-1:0] = ista_r;
      OFF_IMSK: rd_mux[IRQ_W-1:0] = imsk_r;
      default: rd_mux = '0;
    endcase
  end

  // read channel: one read at a time, answer the cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (ce) begin
      if (ar_fire) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r & s_axi_rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end else if (!rvalid_r) begin
        arready_r <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign mode_cfg = mode_r;
  assign dac_cfg = dac_r;
  assign filter_reset = fr_r;
  assign analog_power_down = pd_r;
  assign serial_reset = sr_r;
  assign data_ready_n = rdy_r;
  assign irq = irq_r;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pin_reset_state: assert property (ce & !reset_pin_n |=> (mode_r == MODE_RST) && sr_r && fr_r
    && rdy_r && filter_settled_flag_r && (pd_r == !$past(standby_n)))
    else $error("reset pin effects missing");
  a_standby_powerdown: assert property (ce & !standby_n |=> pd_r && fr_r && rdy_r && filter_settled_flag_r)
    else $error("standby effects missing");
  a_standby_keeps_mode: assert property (ce & !standby_n & !rst_ev & !mode_wr & !cal_end
    |=> $stable(mode_r) && !sr_r)
    else $error("standby changed mode");
  a_pdown_write: assert property (ce & md_wr_ev & !rst_ev & (op_nxt == MD_PDOWN)
    |=> pd_r && fr_r && !sr_r && rdy_r)
    else $error("mode 011 effects missing");
  a_sync_effects: assert property (ce & !sync_n & reset_pin_n & standby_n & !ser_strobe & !mode_wr
    & !cal_end |=> fr_r && rdy_r && filter_settled_flag_r && !sr_r && $stable(mode_r))
    else $error("sync effects wrong");
  a_idle_write_power: assert property (ce & md_wr_ev & !rst_ev & standby_n & (op_nxt == MD_IDLE)
    |=> !pd_r && fr_r && rdy_r && !sr_r)
    else $error("mode 000 write effects wrong");
  a_conv_write_adopt: assert property (ce & md_wr_ev & !rst_ev & (op_nxt != MD_PDOWN)
    |=> (mode_r.operating_mode_bits == $past(op_nxt)) && fr_r && filter_settled_flag_r)
    else $error("mode write not adopted");
  a_ones_soft_reset: assert property (ce & ones_hit |=> sr_r && (mode_r == MODE_RST) && rdy_r)
    else $error("serial ones reset missing");
  a_read_sets_ready: assert property (ce & data_rd & !filt_ev & !word_take |=> rdy_r && $stable(filter_settled_flag_r))
    else $error("data read ready wrong");
  a_cal_end_idle: assert property (ce & cal_end |=> !rdy_r && (mode_r.operating_mode_bits == MD_IDLE))
    else $error("calibration end wrong");
  a_noref_all_ones: assert property (ce & word_take & ref_missing & !rst_ev |=> data_r == '1)
    else $error("missing reference not all ones");
  a_ready_needs_word: assert property (ce & rdy_r & !word_take & !cal_end |=> rdy_r)
    else $error("ready cleared without a word");

  c_cal_done: cover property (ce & cal_end);
  c_ones_reset: cover property (ce & ones_hit);
  c_noref_word: cover property (ce & word_take & ref_missing);
  c_chan_change: cover property (ce & chan_chg ##[1:50] (ce & word_take & word_settled));
endmodule : aec_top

// file: aec_pkg.sv
// constants, field layouts and carrier types for the adc event and input control block
// assumes a 32-bit axi4-lite register bus and one 20 mhz clock
package aec_pkg;
  localparam int AXI_AW = 5;
  localparam int AXI_DW = 32;
  // register byte offsets
  localparam logic [AXI_AW-1:0] OFF_MODE = 5'h00;
  localparam logic [AXI_AW-1:0] OFF_DAC = 5'h04;
  localparam logic [AXI_AW-1:0] OFF_STAT = 5'h08;
  localparam logic [AXI_AW-1:0] OFF_DATA = 5'h0c;
  localparam logic [AXI_AW-1:0] OFF_ISTA = 5'h10;
  localparam logic [AXI_AW-1:0] OFF_IMSK = 5'h14;
  // operating mode codes; bit 2 set means a calibration mode
  localparam logic [2:0] MD_IDLE = 3'h0;
  localparam logic [2:0] MD_CONT = 3'h1;
  localparam logic [2:0] MD_SINGLE = 3'h2;
  localparam logic [2:0] MD_PDOWN = 3'h3;
  localparam int MD_CAL_BIT = 2;
  // mode register layout, low bit first at the bottom
  typedef struct packed {
    logic [1:0] port_bits;
    logic sec_port_en;
    logic chopper_enable;
    logic high_reference_select;
    logic burnout_current_enable;
    logic bipolar;
    logic channel_select_bit1;
    logic channel_select_bit0;
    logic [2:0] operating_mode_bits;
  } aec_mode_type;
  localparam int MODE_W = 12;
  localparam logic [MODE_W-1:0] MODE_RST = 12'h000;
  // offset dac code: sign set means subtract
  typedef struct packed {
    logic sign;
    logic [4:0] magnitude;
  } aec_dac_type;
  localparam int DAC_W = 6;
  localparam logic [DAC_W-1:0] DAC_RST = 6'h00;
  // status register bits
  localparam int ST_RDY = 0;
  localparam int ST_FILTER_SETTLED_FLAG = 1;
  localparam int ST_NOREF = 2;
  // interrupt status and mask bits
  localparam int IRQ_W = 4;
  localparam int IB_WORD = 0;
  localparam int IB_CAL = 1;
  localparam int IB_NOREF = 2;
  localparam int IB_SOFT = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int SER_ONES = 32;
endpackage : aec_pkg

// file: aec_host_ser.sv
// host side of the two-wire serial input: clocks bits into the device one strobe at a time
// assumes send is called just after a rising edge of aclk
`timescale 1ns/1ns
module aec_host_ser (
  input wire logic aclk,
  output logic ser_strobe,
  output logic ser_bit
);
  initial begin
    ser_strobe = 1'b0;
    ser_bit = 1'b0;
  end
  // between strobes the data line shows the inverse, so a stale bit is never mistaken for a good one
  task automatic send(input int n, input logic b, input int gap);
    for (int i = 0; i < n; i++) begin
      ser_bit <= b;
      ser_strobe <= 1'b1;
      @(posedge aclk);
      ser_strobe <= 1'b0;
      ser_bit <= ~b;
      repeat (gap) @(posedge aclk);
    end
  endtask : send
endmodule : aec_host_ser

// file: aec_top_test.sv
// self-checking bench for the adc event and input control block
// assumes aec_pkg, aec_top and the serial host model are compiled first
`timescale 1ns/1ns
module aec_top_test;
  import aec_pkg::*;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ser_strobe, ser_bit, word_valid, word_settled;
  logic ref_missing, cal_done, filter_reset, analog_power_down, serial_reset, data_ready_n, irq;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [AXI_DW-1:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [2:0] pins_n;
  logic [23:0] word;
  aec_mode_type mode_cfg;
  aec_dac_type dac_cfg;
  int error_cnt, check_count, cyc;
  // coding table: mode, filter word, expected result
  logic [11:0] cm [6] = '{12'h021, 12'h021, 12'h021, 12'h001, 12'h001, 12'h001};
  logic [23:0] cw [6] = '{24'h000000, 24'h7fffff, 24'h800000, 24'h000000, 24'h400000, 24'hfffffb};
  logic [23:0] cx [6] = '{24'h800000, 24'hffffff, 24'h000000, 24'h000000, 24'h800000, 24'h000000};

  aec_top aec_top_inst (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .reset_pin_n(pins_n[0]), .standby_n(pins_n[1]), .sync_n(pins_n[2]), .ser_strobe, .ser_bit, .word_valid,
    .word, .word_settled, .ref_missing, .cal_done, .mode_cfg, .dac_cfg, .filter_reset, .analog_power_down,
    .serial_reset, .data_ready_n, .irq);
  aec_host_ser aec_host_ser_inst (.aclk, .ser_strobe, .ser_bit);

  // 20 mhz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // a hung handshake ends the run here instead of spinning forever
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bchk(input string nm, input logic e, input logic g);
    chk(nm, 32'(e), 32'(g));
  endtask : bchk

  task automatic done(input string nm);
    $display("test %s finished, %0d mismatches so far", nm, error_cnt);
  endtask : done

  // address and data offered together, each dropped on its own handshake
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rdr(input logic [4:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rdr

  // one filter word; the leading edges let any filter reset from a mode write run out
  task automatic put(input logic [23:0] w, input logic st);
    repeat (2) @(posedge aclk);
    word <= w;
    word_settled <= st;
    word_valid <= 1'b1;
    @(posedge aclk);
    word_valid <= 1'b0;
    word <= ~w;
    repeat (2) @(posedge aclk);
  endtask : put

  // one-cycle low pulse on a pin: bit 0 reset, bit 1 standby, bit 2 sync
  task automatic pulse(input int k);
    pins_n <= 3'b111 & ~(3'b001 << k);
    @(posedge aclk);
    pins_n <= 3'b111;
    @(posedge aclk);
  endtask : pulse

  task automatic results();
    $display("comparisons %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {word_valid, word_settled, ref_missing, cal_done} = 4'h0;
    ce = 1'b1;
    pins_n = 3'b111;
    word = 24'h000000;
    s_axi_awaddr = 5'h00;
    s_axi_araddr = 5'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    cyc = 0;
    repeat (16) @(posedge aclk);
    bchk("analog down", 1'b1, analog_power_down);
    bchk("serial reset", 1'b1, serial_reset);
    bchk("filter reset", 1'b1, filter_reset);
    bchk("ready_n", 1'b1, data_ready_n);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(OFF_STAT);
    chk("status", 32'h3, rd);
    done("power on");
    wr(OFF_DAC, 32'h25);
    chk("dac", 32'h25, 32'(dac_cfg));
    wr(OFF_DAC, 32'h3f, 4'h0);
    rdr(OFF_DAC);
    chk("dac read", 32'h25, rd);
    wr(OFF_STAT, 32'h0);
    chk("ro bresp", 32'(RESP_SLVERR), 32'(resp));
    rdr(5'h18);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(resp));
    wr(OFF_MODE, 32'h040);
    chk("burnout on", 32'h040, 32'(mode_cfg));
    bchk("analog up", 1'b0, analog_power_down);
    wr(OFF_MODE, 32'he00);
    chk("port mode", 32'he00, 32'(mode_cfg));
    done("registers");
    for (int i = 0; i < 6; i++) begin
      wr(OFF_MODE, 32'(cm[i]));
      bchk("ready_n mode write", 1'b1, data_ready_n);
      put(cw[i], 1'b1);
      bchk("ready_n word", 1'b0, data_ready_n);
      rdr(OFF_DATA);
      chk("result", {8'h00, cx[i]}, rd);
      bchk("ready_n after read", 1'b1, data_ready_n);
      chk("mode after read", 32'(cm[i]), 32'(mode_cfg));
    end
    put(24'h000010, 1'b0);
    bchk("ready_n unsettled", 1'b1, data_ready_n);
    ref_missing <= 1'b1;
    put(24'h123456, 1'b1);
    rdr(OFF_DATA);
    chk("noref result", 32'h00ffffff, rd);
    ref_missing <= 1'b0;
    put(24'h000005, 1'b1);
    wr(OFF_MODE, 32'h009);
    bchk("ready_n channel", 1'b1, data_ready_n);
    put(24'h000005, 1'b0);
    bchk("ready_n not settled", 1'b1, data_ready_n);
    put(24'h000005, 1'b1);
    bchk("ready_n settled", 1'b0, data_ready_n);
    done("coding");
    wr(OFF_MODE, 32'h004);
    chk("cal mode", 32'h004, 32'(mode_cfg));
    bchk("ready_n cal", 1'b1, data_ready_n);
    cal_done <= 1'b1;
    @(posedge aclk);
    cal_done <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("mode after cal", 32'h0, 32'(mode_cfg[2:0]));
    bchk("ready_n after cal", 1'b0, data_ready_n);
    rdr(OFF_ISTA);
    bchk("cal event", 1'b1, rd[IB_CAL]);
    wr(OFF_ISTA, 32'hf);
    wr(OFF_IMSK, 32'h1);
    wr(OFF_MODE, 32'h001);
    put(24'h000001, 1'b1);
    bchk("irq word", 1'b1, irq);
    wr(OFF_IMSK, 32'h0);
    bchk("irq masked", 1'b0, irq);
    wr(OFF_IMSK, 32'h1);
    wr(OFF_ISTA, 32'h1);
    bchk("irq cleared", 1'b0, irq);
    done("interrupts");
    wr(OFF_DAC, 32'h0a);
    wr(OFF_MODE, 32'h003);
    bchk("analog down 011", 1'b1, analog_power_down);
    chk("dac kept 011", 32'h0a, 32'(dac_cfg));
    bchk("ready_n 011", 1'b1, data_ready_n);
    wr(OFF_MODE, 32'h001);
    bchk("analog up", 1'b0, analog_power_down);
    pulse(2);
    bchk("sync filter", 1'b1, filter_reset);
    bchk("sync analog", 1'b0, analog_power_down);
    chk("sync mode", 32'h001, 32'(mode_cfg));
    pulse(1);
    bchk("standby analog", 1'b1, analog_power_down);
    bchk("standby serial", 1'b0, serial_reset);
    chk("standby dac", 32'h0a, 32'(dac_cfg));
    bchk("standby ready_n", 1'b1, data_ready_n);
    wr(OFF_MODE, 32'h001);
    pulse(0);
    bchk("pin serial", 1'b1, serial_reset);
    bchk("pin filter", 1'b1, filter_reset);
    chk("pin mode", 32'h0, 32'(mode_cfg));
    bchk("pin analog", 1'b0, analog_power_down);
    chk("pin dac", 32'h0, 32'(dac_cfg));
    done("pins");
    wr(OFF_DAC, 32'h0a);
    wr(OFF_MODE, 32'h001);
    aec_host_ser_inst.send(31, 1'b1, 1);
    aec_host_ser_inst.send(1, 1'b0, 3);
    repeat (3) @(posedge aclk);
    chk("31 ones mode", 32'h001, 32'(mode_cfg));
    aec_host_ser_inst.send(32, 1'b1, 3);
    repeat (3) @(posedge aclk);
    chk("32 ones mode", 32'h0, 32'(mode_cfg));
    chk("32 ones dac", 32'h0, 32'(dac_cfg));
    bchk("32 ones ready_n", 1'b1, data_ready_n);
    done("serial reset");
    // a reset pin pulse while the clock enable is low must leave every register alone
    wr(OFF_DAC, 32'h0a);
    wr(OFF_MODE, 32'h001);
    ce <= 1'b0;
    pulse(0);
    ce <= 1'b1;
    @(posedge aclk);
    chk("frozen dac", 32'h0a, 32'(dac_cfg));
    chk("frozen mode", 32'h001, 32'(mode_cfg));
    // second power-on reset in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("por mode", 32'h0, 32'(mode_cfg));
    chk("por dac", 32'h0, 32'(dac_cfg));
    bchk("por analog", 1'b1, analog_power_down);
    bchk("por ready_n", 1'b1, data_ready_n);
    aresetn <= 1'b1;
    @(posedge aclk);
    done("enable and reset");
    results();
  end
endmodule : aec_top_test
